/* File: framer_model.sv */
// Far-end framer model that drives line status and bit lines
`timescale 1ns/10ps
module framer_model (
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	input  wire lamp_pkg::line_status_t want_status,
	input  wire logic [3:0]             want_bits,
	output      lamp_pkg::line_status_t line_status,
	output      logic [3:0]             bits
);
	// Registered so every change lands just after an edge, as a framer's would
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			line_status <= '0;
			bits        <= '0;
		end else begin
			line_status <= want_status;
			bits        <= want_bits;
		end
	end
endmodule

/* File: lamp_pkg.sv */
// Constants and types for the line status lamps and loop timer
//
// Behaviour
// - Timeout 5-180 min or never, default 30
// - Never keeps loopback until user ends it
// - Restore defaults keeps headers and password
// - Transmit lamp follows bits in active slots
// - Receive lamp follows bits in active slots
// - Sync-loss lamp; transmit clock when unframed
// - Alarm lamp on sync, frame, AIS, RAI
// - Channels past 24 invalid; half-second error flash
// - Invalid switches run full T1 from channel 1
// - Invalid flash overrides other error indications
// - Pattern test: error lamp on while mismatched
// - Error insertion blinks lamp once per second; code blinks it only while pattern_send is set
// - Framed: brief flash for errored seconds
// - Framing mismatch gives brief flash per second
// - No signal gives brief flash per second
// - Test lamp pattern follows active test
package lamp_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS           = 100;
	localparam int SEC_NS           = 1000000000;
	localparam int SEC_CYCLES_DEF   = SEC_NS / CLK_NS;
	localparam int BRIEF_NS         = 100000000;
	localparam int BRIEF_CYCLES_DEF = BRIEF_NS / CLK_NS;
	localparam int SEC_CNT_W        = 24;
	localparam logic [5:0] SEC_PER_MIN_LAST = 6'h3b;

	// ----------------------------------------------------------------
	// Channels and loop timeout codes
	// ----------------------------------------------------------------
	localparam logic [4:0] T1_CHANNELS     = 5'h18;
	localparam logic [4:0] FIRST_CHANNEL   = 5'h01;
	localparam logic [3:0] TIMEOUT_DEFAULT = 4'h3;
	localparam logic [3:0] TIMEOUT_NEVER   = 4'h9;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CONFIG  = 4'h0;
	localparam logic [3:0] REG_ID      = 4'h4;
	localparam logic [3:0] REG_COMMAND = 4'h8;
	localparam logic [3:0] REG_STATUS  = 4'hc;
	localparam int CMD_RESTORE_BIT  = 0;
	localparam int CMD_END_LOOP_BIT = 1;
	localparam int CFG_W            = 7;
	localparam logic [31:0] ID_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		LOOP_NONE,
		LOOP_LOCAL,
		LOOP_REMOTE,
		LOOP_CO
	} loop_kind_t;

	typedef struct packed {
		logic [3:0] timeout_sel;
		logic       err_insert;
		logic       pattern_send;
		logic       unframed;
	} cfg_t;

	localparam cfg_t CFG_DEFAULT = '{timeout_sel: TIMEOUT_DEFAULT,
		err_insert: 1'b0, pattern_send: 1'b0, unframed: 1'b0};

	typedef struct packed {
		logic sync_lost;
		logic frame_lost;
		logic ais;
		logic rai;
		logic tx_clk_bad;
		logic frame_err;
		logic frame_mismatch;
		logic no_signal;
		logic pattern_mismatch;
		logic loop_pattern_sending;
	} line_status_t;

	typedef struct packed {
		logic tx;
		logic rx;
		logic sync_loss;
		logic alarm;
		logic err;
		logic test;
	} lamps_t;

	typedef struct packed {
		loop_kind_t loop;
		logic       invalid;
		lamps_t     lamps;
		logic [4:0] eff_slots;
		logic [4:0] eff_start;
	} status_word_t;

	// Minutes for a timeout code; zero means never (or an unused code)
	function automatic logic [7:0] timeout_minutes(input logic [3:0] sel);
		logic [7:0] m;
		m = 8'h00;
		unique case (sel)
			4'h0: m = 8'h05;
			4'h1: m = 8'h0a;
			4'h2: m = 8'h0f;
			4'h3: m = 8'h1e;
			4'h4: m = 8'h2d;
			4'h5: m = 8'h3c;
			4'h6: m = 8'h5a;
			4'h7: m = 8'h78;
			4'h8: m = 8'hb4;
			default: m = 8'h00;
		endcase
		return m;
	endfunction

endpackage

/* File: line_status_indicator_and_loop_timer.sv */
// Front-panel lamp driver and loopback timeout for a T1 line unit
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module line_status_indicator_and_loop_timer #(
	parameter int SEC_CYCLES   = lamp_pkg::SEC_CYCLES_DEF,
	parameter int BRIEF_CYCLES = lamp_pkg::BRIEF_CYCLES_DEF
) (
	input  wire logic                  core_clk,
	input  wire logic                  rstn,
	input  wire logic [3:0]            addr,
	input  wire logic [31:0]           wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output      logic [31:0]           rdata,
	input  wire logic [4:0]            sw_start_chan,
	input  wire logic [4:0]            sw_slots,
	input  wire lamp_pkg::line_status_t line_status,
	input  wire logic                  tx_bit,
	input  wire logic                  tx_slot_active,
	input  wire logic                  rx_bit,
	input  wire logic                  rx_slot_active,
	input  wire logic                  loop_start,
	input  wire lamp_pkg::loop_kind_t  loop_req_kind,
	input  wire logic                  loop_stop,
	output      lamp_pkg::lamps_t      lamps,
	output      lamp_pkg::loop_kind_t  loop_kind,
	output      logic                  loop_timeout,
	output      logic [4:0]            eff_start_chan,
	output      logic [4:0]            eff_slots,
	output      logic                  pattern_send,
	output      logic                  err_insert
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0]                    sw_a_start;
		logic [4:0]                    sw_a_slots;
		logic [4:0]                    sw_b_start;
		logic [4:0]                    sw_b_slots;
		lamp_pkg::cfg_t                cfg;
		logic [31:0]                   id;
		logic [31:0]                   rdata;
		logic [lamp_pkg::SEC_CNT_W-1:0] sec_cnt;
		logic [5:0]                    loop_sec;
		logic [7:0]                    loop_min;
		logic                          fe_seen;
		logic                          fe_last;
		lamp_pkg::loop_kind_t          loop;
		logic                          timeout_pulse;
		logic                          invalid;
		logic [4:0]                    eff_start;
		logic [4:0]                    eff_slots;
		lamp_pkg::lamps_t              lamps;
	} state_t;

	localparam state_t ST_RESET = '{
		sw_a_start: 5'h00, sw_a_slots: 5'h00,
		sw_b_start: 5'h00, sw_b_slots: 5'h00,
		cfg: lamp_pkg::CFG_DEFAULT, id: lamp_pkg::ID_RESET,
		rdata: 32'h0000_0000, sec_cnt: '0, loop_sec: 6'h00,
		loop_min: 8'h00, fe_seen: 1'b0, fe_last: 1'b0,
		loop: lamp_pkg::LOOP_NONE, timeout_pulse: 1'b0,
		invalid: 1'b0, eff_start: lamp_pkg::FIRST_CHANNEL,
		eff_slots: lamp_pkg::T1_CHANNELS, lamps: '0};

	// Local copy of the counter width so the size casts below stay simple
	localparam int SEC_W = lamp_pkg::SEC_CNT_W;
	localparam logic [SEC_W-1:0] SEC_LAST  = SEC_W'(SEC_CYCLES - 1);
	localparam logic [SEC_W-1:0] SEC_HALF  = SEC_W'(SEC_CYCLES / 2);
	localparam logic [SEC_W-1:0] BRIEF_LEN = SEC_W'(BRIEF_CYCLES);

	state_t st;
	state_t next_st;

	logic       tick;
	logic       brief;
	logic       half;
	logic       cfg_wr;
	logic       id_wr;
	logic       cmd_wr;
	logic       restore;
	logic       end_cmd;
	logic [5:0] chan_sum;
	logic       sw_invalid;
	logic [7:0] limit_min;
	logic       expired;
	lamp_pkg::cfg_t      cfg_in;
	lamp_pkg::status_word_t status_word;

	assign tick    = st.sec_cnt == SEC_LAST;
	assign brief   = st.sec_cnt < BRIEF_LEN;
	assign half    = st.sec_cnt < SEC_HALF;
	assign cfg_wr  = wr && addr == lamp_pkg::REG_CONFIG;
	assign id_wr   = wr && addr == lamp_pkg::REG_ID;
	assign cmd_wr  = wr && addr == lamp_pkg::REG_COMMAND;
	assign restore = cmd_wr && wdata[lamp_pkg::CMD_RESTORE_BIT];
	assign end_cmd = cmd_wr && wdata[lamp_pkg::CMD_END_LOOP_BIT];
	assign cfg_in  = lamp_pkg::cfg_t'(wdata[lamp_pkg::CFG_W-1:0]);

	// A start channel plus slot count must end at or before the last one
	assign chan_sum   = {1'b0, st.sw_b_start} + {1'b0, st.sw_b_slots};
	assign sw_invalid = st.sw_b_start == 5'h00 || st.sw_b_slots == 5'h00 ||
		chan_sum > {1'b0, lamp_pkg::T1_CHANNELS} + 6'h01;

	// Zero minutes stands for never: such a loop only ends on command
	assign limit_min = lamp_pkg::timeout_minutes(st.cfg.timeout_sel);
	assign expired   = st.loop != lamp_pkg::LOOP_NONE &&
		limit_min != 8'h00 && st.loop_min >= limit_min;

	assign status_word = '{loop: st.loop, invalid: st.invalid,
		lamps: st.lamps, eff_slots: st.eff_slots,
		eff_start: st.eff_start};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;

		// Switch pins pass two flip-flops before use
		next_st.sw_a_start = sw_start_chan;
		next_st.sw_a_slots = sw_slots;
		next_st.sw_b_start = st.sw_a_start;
		next_st.sw_b_slots = st.sw_a_slots;

		next_st.sec_cnt = tick ? '0 : st.sec_cnt + 1'b1;

		// Registers; unused timeout codes leave the selection as it was
		if (cfg_wr) begin
			next_st.cfg = cfg_in;
			if (cfg_in.timeout_sel > lamp_pkg::TIMEOUT_NEVER) begin
				next_st.cfg.timeout_sel = st.cfg.timeout_sel;
			end
		end
		if (id_wr) begin
			next_st.id = wdata;
		end
		if (restore) begin
			next_st.cfg = lamp_pkg::CFG_DEFAULT;
		end
		next_st.rdata = 32'h0000_0000;
		if (rd) begin
			case (addr)
				lamp_pkg::REG_CONFIG: next_st.rdata = 32'(st.cfg);
				lamp_pkg::REG_ID:     next_st.rdata = st.id;
				lamp_pkg::REG_STATUS: next_st.rdata = 32'(status_word);
				default:              next_st.rdata = 32'h0000_0000;
			endcase
		end

		// Switch validation
		next_st.invalid = sw_invalid;
		if (sw_invalid) begin
			next_st.eff_start = lamp_pkg::FIRST_CHANNEL;
			next_st.eff_slots = lamp_pkg::T1_CHANNELS;
		end else begin
			next_st.eff_start = st.sw_b_start;
			next_st.eff_slots = st.sw_b_slots;
		end

		// Loop timer; a new start wins over a stop or a timeout
		next_st.timeout_pulse = 1'b0;
		if (st.loop != lamp_pkg::LOOP_NONE && tick) begin
			if (st.loop_sec == lamp_pkg::SEC_PER_MIN_LAST) begin
				next_st.loop_sec = 6'h00;
				if (st.loop_min != 8'hff) begin
					next_st.loop_min = st.loop_min + 8'h01;
				end
			end else begin
				next_st.loop_sec = st.loop_sec + 6'h01;
			end
		end
		if (expired) begin
			next_st.loop          = lamp_pkg::LOOP_NONE;
			next_st.timeout_pulse = 1'b1;
		end
		if (loop_stop || end_cmd) begin
			next_st.loop = lamp_pkg::LOOP_NONE;
		end
		if (loop_start) begin
			next_st.loop     = loop_req_kind;
			next_st.loop_sec = 6'h00;
			next_st.loop_min = 8'h00;
		end

		// Errored seconds; an error in the closing cycle still counts
		if (tick) begin
			next_st.fe_last = st.fe_seen ||
				(line_status.frame_err && !st.cfg.unframed);
			next_st.fe_seen = 1'b0;
		end else if (line_status.frame_err && !st.cfg.unframed) begin
			next_st.fe_seen = 1'b1;
		end

		// Lamps
		next_st.lamps.tx = tx_bit && tx_slot_active;
		next_st.lamps.rx = rx_bit && rx_slot_active;
		next_st.lamps.sync_loss = st.cfg.unframed ?
			line_status.tx_clk_bad : line_status.sync_lost;
		next_st.lamps.alarm = line_status.sync_lost ||
			line_status.frame_lost || line_status.ais ||
			line_status.rai;

		if (st.invalid) begin
			next_st.lamps.err = half;
		end else if (st.cfg.pattern_send) begin
			if (line_status.pattern_mismatch) begin
				next_st.lamps.err = 1'b1;
			end else begin
				next_st.lamps.err = st.cfg.err_insert && brief;
			end
		end else begin
			next_st.lamps.err = brief && (st.fe_last ||
				line_status.frame_mismatch ||
				line_status.no_signal);
		end

		if (st.cfg.pattern_send || line_status.loop_pattern_sending) begin
			next_st.lamps.test = 1'b1;
		end else begin
			unique case (st.loop)
				lamp_pkg::LOOP_NONE:   next_st.lamps.test = 1'b0;
				lamp_pkg::LOOP_LOCAL:  next_st.lamps.test = brief;
				lamp_pkg::LOOP_REMOTE: next_st.lamps.test = !brief;
				lamp_pkg::LOOP_CO:     next_st.lamps.test = !brief;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign rdata          = st.rdata;
	assign lamps          = st.lamps;
	assign loop_kind      = st.loop;
	assign loop_timeout   = st.timeout_pulse;
	assign eff_start_chan = st.eff_start;
	assign eff_slots      = st.eff_slots;
	assign pattern_send   = st.cfg.pattern_send;
	assign err_insert     = st.cfg.err_insert;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_restore_cmd;
		restore;
	endsequence

	sequence s_loop_expire;
		expired && !loop_start;
	endsequence

	a_tx_lamp_follow: assert property (
		1'b1 |=> lamps.tx == $past(tx_bit && tx_slot_active))
		else $error("transmit lamp does not follow transmit bit");

	a_rx_lamp_follow: assert property (
		1'b1 |=> lamps.rx == $past(rx_bit && rx_slot_active))
		else $error("receive lamp does not follow receive bit");

	a_sync_lamp_src: assert property (
		st.cfg.unframed && line_status.tx_clk_bad |=> lamps.sync_loss)
		else $error("sync-loss lamp ignores transmit clock when unframed");

	a_alarm_any: assert property (
		1'b1 |=> lamps.alarm == $past(line_status.sync_lost ||
			line_status.frame_lost || line_status.ais || line_status.rai))
		else $error("alarm lamp does not match alarm conditions");

	a_invalid_full_t1: assert property (
		st.invalid |-> eff_start_chan == lamp_pkg::FIRST_CHANNEL &&
			eff_slots == lamp_pkg::T1_CHANNELS)
		else $error("invalid switches not replaced by full T1");

	a_invalid_flash: assert property (
		st.invalid |=> lamps.err == $past(half))
		else $error("invalid flash not overriding other errors");

	a_mismatch_lit: assert property (
		!st.invalid && st.cfg.pattern_send &&
			line_status.pattern_mismatch |=> lamps.err)
		else $error("error lamp dark while pattern mismatches");

	a_restore_keeps: assert property (
		s_restore_cmd |=> st.cfg == lamp_pkg::CFG_DEFAULT &&
			st.id == $past(st.id))
		else $error("restore changed identity or missed a default");

	a_loop_timeout: assert property (
		s_loop_expire |=> loop_timeout && loop_kind == lamp_pkg::LOOP_NONE)
		else $error("expired loopback not ended");

	a_never_holds: assert property (
		st.loop != lamp_pkg::LOOP_NONE &&
			st.cfg.timeout_sel == lamp_pkg::TIMEOUT_NEVER &&
			!loop_start && !loop_stop && !end_cmd
		|=> loop_kind == $past(st.loop) && !loop_timeout)
		else $error("never timeout dropped a loopback");

	a_test_steady: assert property (
		st.cfg.pattern_send |=> lamps.test)
		else $error("test lamp not steady while sending pattern");

	a_test_blink: assert property (
		!st.cfg.pattern_send && !line_status.loop_pattern_sending &&
			st.loop != lamp_pkg::LOOP_NONE
		|=> lamps.test == ($past(st.loop) == lamp_pkg::LOOP_LOCAL ?
			$past(brief) : !$past(brief)))
		else $error("test lamp blink does not match loopback kind");

	a_stop_ends_loop: assert property (
		(loop_stop || end_cmd) && !loop_start
		|=> loop_kind == lamp_pkg::LOOP_NONE)
		else $error("user stop did not end loopback");

	a_timeout_single: assert property (
		loop_timeout |=> !loop_timeout)
		else $error("loop timeout pulse longer than one cycle");

	a_err_brief_only: assert property (
		!st.invalid && !st.cfg.pattern_send && !brief |=> !lamps.err)
		else $error("brief error flash outlasted its window");

	a_noise_flash: assert property (
		!st.invalid && !st.cfg.pattern_send && brief &&
			line_status.no_signal |=> lamps.err)
		else $error("no-signal flash missing");

	a_insert_blink: assert property (
		!st.invalid && st.cfg.pattern_send && st.cfg.err_insert &&
			!line_status.pattern_mismatch |=> lamps.err == $past(brief))
		else $error("error insertion blink wrong");

	// An error closing a second must show in the next second's flash
	sequence s_errored_close;
		tick && (st.fe_seen || line_status.frame_err) && !st.cfg.unframed;
	endsequence

	a_errored_second: assert property (
		s_errored_close ##1 (!st.invalid && !st.cfg.pattern_send && brief)
		|=> lamps.err)
		else $error("errored second not flashed");

endmodule

/* File: line_status_indicator_and_loop_timer_tb.sv */
// Self-checking bench for the lamp driver and loop timer
`timescale 1ns/10ps
module line_status_indicator_and_loop_timer_tb;
	localparam int SEC   = 40;
	localparam int BRIEF = 4;
	logic                   core_clk, rstn, wr, rd, loop_start, loop_stop;
	logic                   loop_timeout, pattern_send, err_insert;
	logic [3:0]             addr, want_bits, bits;
	logic [31:0]            wdata, rdata, d;
	logic [4:0]             sw_start_chan, sw_slots, eff_start_chan, eff_slots;
	lamp_pkg::line_status_t want, line_status;
	lamp_pkg::loop_kind_t   loop_req_kind, loop_kind;
	lamp_pkg::lamps_t       lamps;
	int                     fail_count, total_checks, n;
	logic [3:0]             bv [3] = '{4'ha, 4'hf, 4'h5};
	logic [31:0]            ev [3] = '{32'h0, 32'h3, 32'h0};

	line_status_indicator_and_loop_timer #(.SEC_CYCLES(SEC),
		.BRIEF_CYCLES(BRIEF)) dut (.core_clk(core_clk), .rstn(rstn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sw_start_chan(sw_start_chan), .sw_slots(sw_slots),
		.line_status(line_status), .tx_bit(bits[3]),
		.tx_slot_active(bits[2]), .rx_bit(bits[1]),
		.rx_slot_active(bits[0]), .loop_start(loop_start),
		.loop_req_kind(loop_req_kind), .loop_stop(loop_stop),
		.lamps(lamps), .loop_kind(loop_kind), .loop_timeout(loop_timeout),
		.eff_start_chan(eff_start_chan), .eff_slots(eff_slots),
		.pattern_send(pattern_send), .err_insert(err_insert));
	framer_model far_end (.core_clk(core_clk), .rstn(rstn),
		.want_status(want), .want_bits(want_bits),
		.line_status(line_status), .bits(bits));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a);
		@(posedge core_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		@(negedge core_clk);
		d = rdata;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		reg_rd(a);
		check(d, exp);
	endtask
	task automatic wait_cyc(input int c);
		repeat (c) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	// Lit cycles of one lamp over a span; phase of the second does not matter
	task automatic count_on(input int idx, input int len, input int exp);
		int c;
		c = 0;
		repeat (len) begin
			@(negedge core_clk);
			c += int'(lamps[idx]);
		end
		check(32'(c), 32'(exp));
	endtask
	task automatic start_loop(input int k);
		@(posedge core_clk);
		loop_start <= 1'b1;
		loop_req_kind <= lamp_pkg::loop_kind_t'(k);
		@(posedge core_clk);
		loop_start <= 1'b0;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Whole run is about 25000 cycles; allow well over double
	initial begin
		#(60000 * 100);
		fail_count++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		loop_start = 1'b0;
		loop_stop = 1'b0;
		loop_req_kind = lamp_pkg::LOOP_NONE;
		sw_start_chan = 5'h01;
		sw_slots = 5'h18;
		want = '0;
		want_bits = 4'h0;
		fail_count = 0;
		total_checks = 0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		wait_cyc(5);
		rd_chk(lamp_pkg::REG_CONFIG, 32'h18);
		for (int i = 0; i < 3; i++) begin
			want_bits <= bv[i];
			wait_cyc(3);
			check({30'h0, lamps.tx, lamps.rx}, ev[i]);
		end
		for (int i = 0; i < 4; i++) begin
			want <= lamp_pkg::line_status_t'(10'h200 >> i);
			wait_cyc(3);
			check({31'h0, lamps.alarm}, 32'h1);
			check({31'h0, lamps.sync_loss}, 32'(i == 0));
		end
		reg_wr(lamp_pkg::REG_CONFIG, 32'h19);
		want <= lamp_pkg::line_status_t'(10'h020);
		wait_cyc(3);
		check({30'h0, lamps.sync_loss, lamps.alarm}, 32'h2);
		reg_wr(lamp_pkg::REG_CONFIG, 32'h18);
		want <= lamp_pkg::line_status_t'(10'h004);
		wait_cyc(3);
		count_on(1, SEC, BRIEF);
		want <= lamp_pkg::line_status_t'(10'h008);
		wait_cyc(3);
		count_on(1, SEC, BRIEF);
		// Let the mismatch flash die away so only the errored second shows
		want <= '0;
		wait_cyc(3);
		want <= lamp_pkg::line_status_t'(10'h010);
		@(posedge core_clk);
		want <= '0;
		count_on(1, 2 * SEC, BRIEF);
		// Start 12 with 14 slots runs past the last channel
		want <= lamp_pkg::line_status_t'(10'h004);
		@(posedge core_clk);
		sw_start_chan <= 5'h0c;
		sw_slots <= 5'h0e;
		wait_cyc(6);
		check({22'h0, eff_start_chan, eff_slots}, 32'h38);
		// Error lamp bit is masked: its phase in the second is unknown here
		reg_rd(lamp_pkg::REG_STATUS);
		check(d & 32'hffff_f7ff, 32'h0001_0301);
		count_on(1, SEC, SEC / 2);
		@(posedge core_clk);
		sw_slots <= 5'h0d;
		wait_cyc(6);
		check({22'h0, eff_start_chan, eff_slots}, 32'h18d);
		count_on(1, SEC, BRIEF);
		reg_wr(lamp_pkg::REG_CONFIG, 32'h1a);
		want <= lamp_pkg::line_status_t'(10'h002);
		wait_cyc(3);
		count_on(1, SEC, SEC);
		count_on(0, SEC, SEC);
		want <= '0;
		wait_cyc(3);
		count_on(1, SEC, 0);
		reg_wr(lamp_pkg::REG_CONFIG, 32'h1e);
		wait_cyc(3);
		check({30'h0, pattern_send, err_insert}, 32'h3);
		count_on(1, SEC, BRIEF);
		reg_wr(lamp_pkg::REG_CONFIG, 32'h18);
		want <= lamp_pkg::line_status_t'(10'h001);
		wait_cyc(3);
		count_on(0, SEC, SEC);
		want <= '0;
		for (int k = 1; k < 4; k++) begin
			start_loop(k);
			wait_cyc(3);
			check({30'h0, loop_kind}, 32'(k));
			count_on(0, SEC, k == 1 ? BRIEF : SEC - BRIEF);
		end
		@(posedge core_clk);
		loop_stop <= 1'b1;
		@(posedge core_clk);
		loop_stop <= 1'b0;
		wait_cyc(1);
		check({30'h0, loop_kind}, 32'h0);
		// Five minute limit is 300 seconds of SEC cycles, first may be short
		reg_wr(lamp_pkg::REG_CONFIG, 32'h00);
		start_loop(1);
		n = 0;
		while (loop_timeout !== 1'b1 && n < 13000) begin
			@(negedge core_clk);
			n++;
		end
		d = 32'(n >= 299 * SEC && n <= 300 * SEC + 4);
		check(d, 32'h1);
		check({30'h0, loop_kind}, 32'h0);
		@(negedge core_clk);
		check({31'h0, loop_timeout}, 32'h0);
		reg_wr(lamp_pkg::REG_CONFIG, 32'h48);
		reg_wr(lamp_pkg::REG_CONFIG, 32'h78);
		rd_chk(lamp_pkg::REG_CONFIG, 32'h48);
		start_loop(2);
		wait_cyc(12100);
		check({30'h0, loop_kind}, 32'h2);
		reg_wr(lamp_pkg::REG_COMMAND, 32'h2);
		wait_cyc(1);
		check({30'h0, loop_kind}, 32'h0);
		reg_wr(lamp_pkg::REG_ID, 32'h5a5a_a5a5);
		reg_wr(lamp_pkg::REG_CONFIG, 32'h4e);
		rd_chk(lamp_pkg::REG_CONFIG, 32'h4e);
		reg_wr(lamp_pkg::REG_COMMAND, 32'h1);
		rd_chk(lamp_pkg::REG_CONFIG, 32'h18);
		rd_chk(lamp_pkg::REG_ID, 32'h5a5a_a5a5);
		rd_chk(4'h1, 32'h0);
		report_and_stop();
	end
endmodule
